// ### conv_ctrl_pkg.sv
// constants for the conversion start and overtemperature controller
// assumes a single 125 MHz clock; all times converted to cycles here
package conv_ctrl_pkg;
    localparam int CLK_MHZ = 125;
    // times in nanoseconds, as specified
    localparam int PWRUP_NS = 4000;
    localparam int AUTO_DLY_NS = 3000;
    localparam int CONV_AIN_NS = 15000;
    localparam int CONV_TEMP_NS = 30000;
    localparam int RES_BITS = 10;
    localparam int SET_BITS = 8;
    // least time rounds up
    localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
    localparam int AUTO_DLY_CYC = (AUTO_DLY_NS * CLK_MHZ + 999) / 1000;
    // longest time rounds down, split over the bit decisions
    localparam int BIT_AIN_CYC = (CONV_AIN_NS * CLK_MHZ / 1000) / RES_BITS;
    localparam int BIT_TEMP_CYC = (CONV_TEMP_NS * CLK_MHZ / 1000) / RES_BITS;
    localparam int CNT_W = 12;
    localparam logic [2:0] CH_TEMP = 3'h0;
    localparam logic [2:0] CH_AIN = 3'h4;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [9:0] MSB_TRIAL = 10'h200;
    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_PWRUP    = 3'b001,
        ST_WAIT_LOW = 3'b010,
        ST_AUTO     = 3'b011,
        ST_CONVERT  = 3'b100
    } conv_state_t;
endpackage

// ### conv_ctrl.sv
// conversion start sequencing, successive approximation and overtemperature flag
// assumes synchronous inputs; the comparator input reflects the analog compare of the current trial code
// Functional notes
// - flag overtemperature when a sensor-channel result exceeds the 8-bit setpoint.
// - clear the overtemperature flag once a host serial read completes.
// - rising start edge powers up the converter; power-up lasts 4 us.
// - start pulse longer than 4 us: falling edge enters hold and converts.
// - short start pulse: stay in track until power-up elapses, then convert.
// - return to track as soon as each conversion finishes.
// - analog channel conversion finishes within 15 us, 10-bit SAR result.
// - sensor channel, channel 0, conversion takes 30 us.
// - every serial read or write completed while idle starts a conversion, hold about 3 us later; a rising start edge in the same cycle wins, with power-up timing.
`timescale 1ns/1ns
module conv_ctrl (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       conversion_start_input,
    input  wire logic [2:0] channel_sel,
    input  wire logic [7:0] overtemp_setpoint,
    input  wire logic       xfer_done,
    input  wire logic       xfer_is_read,
    input  wire logic       cmp_in,
    output logic            powered_up,
    output logic            hold_mode,
    output logic [2:0]      active_channel,
    output logic [9:0]      dac_code,
    output logic [9:0]      result,
    output logic            result_valid,
    output logic            overtemp_indicator_o,
    output logic            overtemp_indicator_oe
);
    conv_ctrl_pkg::conv_state_t state_r, state_nxt;
    // one counter paces power-up, auto delay and bit periods; every count fits in it
    logic [conv_ctrl_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [3:0] bit_r, bit_nxt;
    // start history resets low: a start held high through reset counts as an edge
    logic       start_q_r, start_q_nxt;
    logic       pwr_r, pwr_nxt;
    logic       hold_r, hold_nxt;
    logic [2:0] ch_r, ch_nxt;
    logic [9:0] dac_r, dac_nxt;
    logic [9:0] res_r, res_nxt;
    logic       valid_r, valid_nxt;
    logic       ot_r, ot_nxt;
    // decoded events of the current cycle
    logic       rise, fall, bit_end, conv_end, hot, ot_set;
    logic [9:0] trial;
    logic [9:0] kept;

    assign rise = conversion_start_input & ~start_q_r;
    assign fall = ~conversion_start_input & start_q_r;
    // sensor channel paces slower bit decisions
    assign bit_end = (ch_r == conv_ctrl_pkg::CH_TEMP) ?
                     (cnt_r == conv_ctrl_pkg::CNT_W'(conv_ctrl_pkg::BIT_TEMP_CYC - 1)) :
                     (cnt_r == conv_ctrl_pkg::CNT_W'(conv_ctrl_pkg::BIT_AIN_CYC - 1));
    // the last decision of the lowest bit ends the conversion
    assign conv_end = (state_r == conv_ctrl_pkg::ST_CONVERT) && bit_end && (bit_r == 4'h0);
    // one decision per code bit: the bit under trial is kept only when the
    // comparator says the input is at or above the trial code
    for (genvar gi = 0; gi < conv_ctrl_pkg::RES_BITS; gi++) begin
        assign trial[gi] = (bit_r == 4'(gi));
        assign kept[gi]  = dac_r[gi] & (cmp_in | ~trial[gi]);
    end
    // sensor code is two's complement quarter degrees; compare whole degrees signed
    assign hot = $signed(kept[9:2]) > $signed(overtemp_setpoint);
    assign ot_set = conv_end && (ch_r == conv_ctrl_pkg::CH_TEMP) && hot;

    // sequencer: power-up, start timing and successive approximation
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        pwr_nxt = pwr_r;
        hold_nxt = hold_r;
        ch_nxt = ch_r;
        dac_nxt = dac_r;
        res_nxt = res_r;
        valid_nxt = 1'b0;
        case (state_r)
            // requests are taken only while idle; busy ones are dropped silently
            conv_ctrl_pkg::ST_OFF: begin
                cnt_nxt = '0;
                if (rise) begin
                    pwr_nxt = 1'b1;
                    state_nxt = conv_ctrl_pkg::ST_PWRUP;
                end else if (xfer_done) begin
                    pwr_nxt = 1'b1;
                    state_nxt = conv_ctrl_pkg::ST_AUTO;
                end
            end

            conv_ctrl_pkg::ST_PWRUP: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == conv_ctrl_pkg::CNT_W'(conv_ctrl_pkg::PWRUP_CYC - 1)) begin
                    cnt_nxt = '0;
                    // a pulse already gone low waits only for the timer
                    if (conversion_start_input) begin
                        state_nxt = conv_ctrl_pkg::ST_WAIT_LOW;
                    end else begin
                        state_nxt = conv_ctrl_pkg::ST_CONVERT;
                    end
                end
            end

            // long pulse: hold waits for the falling edge
            conv_ctrl_pkg::ST_WAIT_LOW: begin
                cnt_nxt = '0;
                if (fall) begin
                    state_nxt = conv_ctrl_pkg::ST_CONVERT;
                end
            end

            // a finished serial transfer restarts the oscillator; hold follows a fixed delay
            conv_ctrl_pkg::ST_AUTO: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == conv_ctrl_pkg::CNT_W'(conv_ctrl_pkg::AUTO_DLY_CYC - 1)) begin
                    cnt_nxt = '0;
                    state_nxt = conv_ctrl_pkg::ST_CONVERT;
                end
            end

            conv_ctrl_pkg::ST_CONVERT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (bit_end) begin
                    cnt_nxt = '0;
                    dac_nxt = kept | (trial >> 1);
                    bit_nxt = bit_r - 1'b1;
                    if (bit_r == 4'h0) begin
                        res_nxt = kept;
                        valid_nxt = 1'b1;
                        hold_nxt = 1'b0;
                        // power drops with the last decision, so the next start edge is taken at once
                        pwr_nxt = 1'b0;
                        bit_nxt = 4'h9;
                        state_nxt = conv_ctrl_pkg::ST_OFF;
                    end
                end
            end

            // unused codes fall back to idle with the converter off
            default: begin
                state_nxt = conv_ctrl_pkg::ST_OFF;
                pwr_nxt = 1'b0;
                hold_nxt = 1'b0;
            end
        endcase
        // entering conversion: go to hold, latch channel, try the msb first
        if (state_r != conv_ctrl_pkg::ST_CONVERT && state_nxt == conv_ctrl_pkg::ST_CONVERT) begin
            hold_nxt = 1'b1;
            ch_nxt = channel_sel;
            dac_nxt = conv_ctrl_pkg::MSB_TRIAL;
            bit_nxt = 4'h9;
        end
    end

    // a result that trips the limit in the same cycle as a read clear wins
    always_comb begin
        ot_nxt = ot_r;
        if (xfer_done && xfer_is_read) begin
            ot_nxt = 1'b0;
        end
        if (ot_set) begin
            ot_nxt = 1'b1;
        end
    end

    // start input history for edge detection
    always_comb begin
        start_q_nxt = conversion_start_input;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            start_q_r <= 1'b0;
        end else begin
            start_q_r <= start_q_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= conv_ctrl_pkg::ST_OFF;
            cnt_r <= '0;
            bit_r <= 4'h9;
            pwr_r <= 1'b0;
            hold_r <= 1'b0;
            ch_r <= conv_ctrl_pkg::CH_TEMP;
            dac_r <= conv_ctrl_pkg::RESULT_RST;
            res_r <= conv_ctrl_pkg::RESULT_RST;
            valid_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            pwr_r <= pwr_nxt;
            hold_r <= hold_nxt;
            ch_r <= ch_nxt;
            dac_r <= dac_nxt;
            res_r <= res_nxt;
            valid_r <= valid_nxt;
        end
    end

    // overtemperature flag register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ot_r <= 1'b0;
        end else begin
            ot_r <= ot_nxt;
        end
    end

    // every output except overtemp_indicator_o, which is tied low, is taken straight from a register
    assign powered_up = pwr_r;
    assign hold_mode = hold_r;
    assign active_channel = ch_r;
    assign dac_code = dac_r;
    assign result = res_r;
    assign result_valid = valid_r;
    // open-drain: pulls the pin low while the flag is set, released otherwise
    assign overtemp_indicator_o = 1'b0;
    assign overtemp_indicator_oe = ot_r;
endmodule

// ### conv_ctrl_chk.sv
// port checker for conv_ctrl
// assumes one mclk domain; bound to the design below
`timescale 1ns/1ns
module conv_ctrl_chk (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       conversion_start_input,
    input wire logic [7:0] overtemp_setpoint,
    input wire logic       xfer_done,
    input wire logic       xfer_is_read,
    input wire logic       powered_up,
    input wire logic       hold_mode,
    input wire logic [2:0] active_channel,
    input wire logic [9:0] dac_code,
    input wire logic [9:0] result,
    input wire logic       result_valid,
    input wire logic       overtemp_indicator_oe
);
    logic [11:0] pcnt_r;
    logic [11:0] hcnt_r;
    // attempts start one edge after release, so no history reaches back across a reset
    logic        armed_r;
    // track and hold cycle counts; too long for a repetition operator
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_r <= 12'h000;
            hcnt_r <= 12'h000;
            armed_r <= 1'b0;
        end else begin
            pcnt_r <= (powered_up && !hold_mode) ? pcnt_r + 12'h001 : 12'h000;
            hcnt_r <= hold_mode ? hcnt_r + 12'h001 : 12'h000;
            armed_r <= 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n || !armed_r);
    pwr_start_a: assert property (conversion_start_input && !$past(conversion_start_input) && !powered_up
        |=> powered_up) else $error("start edge did not power up");
    hold_gate_a: assert property ($rose(hold_mode) |-> pcnt_r == 12'h177 || pcnt_r >= 12'h1f4)
        else $error("hold entered too early");
    long_fall_a: assert property ($fell(conversion_start_input) && powered_up && !hold_mode
        && pcnt_r > 12'h1f4 |=> $rose(hold_mode)) else $error("falling edge did not start hold");
    conv_len_a: assert property ($fell(hold_mode) |-> (active_channel == conv_ctrl_pkg::CH_TEMP)
        ? hcnt_r inside {[12'he99:12'hea6]} : hcnt_r inside {[12'h749:12'h753]}) else $error("bad length");
    conv_end_a: assert property ($fell(hold_mode) |-> result_valid && !powered_up)
        else $error("track not restored at end");
    result_keep_a: assert property (!result_valid |-> $stable(result)) else $error("result moved");
    oti_set_a: assert property (result_valid && active_channel == conv_ctrl_pkg::CH_TEMP
        && $signed(result[9:2]) > $signed(overtemp_setpoint) |-> ##[0:1] overtemp_indicator_oe)
        else $error("overtemp not flagged");
    oti_clr_a: assert property (xfer_done && xfer_is_read && !hold_mode |=> !overtemp_indicator_oe)
        else $error("overtemp not cleared by read");
    sar_first_a: assert property ($rose(hold_mode) |-> dac_code == conv_ctrl_pkg::MSB_TRIAL)
        else $error("conversion did not try the top bit first");
    cover property ($rose(hold_mode) && pcnt_r == 12'h177);
    cover property ($fell(conversion_start_input) && powered_up && !hold_mode);
    cover property (overtemp_indicator_oe && xfer_done && xfer_is_read);
endmodule
bind conv_ctrl conv_ctrl_chk chk (
    .mclk                   (mclk),
    .rst_n                  (rst_n),
    .conversion_start_input (conversion_start_input),
    .overtemp_setpoint      (overtemp_setpoint),
    .xfer_done              (xfer_done),
    .xfer_is_read           (xfer_is_read),
    .powered_up             (powered_up),
    .hold_mode              (hold_mode),
    .active_channel         (active_channel),
    .dac_code               (dac_code),
    .result                 (result),
    .result_valid           (result_valid),
    .overtemp_indicator_oe  (overtemp_indicator_oe)
);

// ### host_model.sv
// host and analog source at the far side of conv_ctrl
// assumes tasks are called from the mclk domain
`timescale 1ns/1ns
module host_model (
    input  wire logic [9:0] dac_code,
    input  wire logic [9:0] level,
    input  wire logic       mclk,
    output logic            conversion_start_input,
    output logic            xfer_done,
    output logic            xfer_is_read,
    output logic            cmp_in
);
    // ideal comparator, so a conversion must return level exactly
    assign cmp_in = level >= dac_code;
    initial conversion_start_input = 1'b0;
    initial xfer_done = 1'b0;
    initial xfer_is_read = 1'b0;
    task automatic pulse(input int len);
        @(posedge mclk) conversion_start_input <= 1'b1;
        repeat (len) @(posedge mclk);
        conversion_start_input <= 1'b0;
    endtask
    task automatic xfer(input logic rd);
        @(posedge mclk) xfer_done <= 1'b1;
        xfer_is_read <= rd;
        @(posedge mclk) xfer_done <= 1'b0;
        // qualifier is stale once the pulse is gone
        xfer_is_read <= !rd;
    endtask
endmodule

// ### conv_ctrl_tb.sv
// self-checking bench for conv_ctrl
// assumes host_model as the far side and the bound checker
`timescale 1ns/1ns
module conv_ctrl_tb;
    typedef struct packed {
        logic [2:0]  ch;
        logic [9:0]  lvl;
        logic [7:0]  sp;
        logic [11:0] len;
        logic        hot;
        logic [11:0] ntrk;
    } row_t;
    // inputs, then the flag state and the track time that the rules give for them
    row_t rows [6] = '{'{3'h0, 10'h0c8, 8'h31, 12'h004, 1'h1, 12'h1f4},
        '{3'h0, 10'h0c8, 8'h32, 12'h258, 1'h0, 12'h258},
        '{3'h0, 10'h3fc, 8'hfe, 12'h004, 1'h1, 12'h1f4},
        '{3'h0, 10'h204, 8'h7f, 12'h2bc, 1'h0, 12'h2bc},
        '{3'h4, 10'h3ff, 8'h00, 12'h2bc, 1'h0, 12'h2bc},
        '{3'h4, 10'h000, 8'h80, 12'h004, 1'h0, 12'h1f4}};
    logic mclk = 1'b0, rst_n = 1'b0, conversion_start_input, xfer_done, xfer_is_read, cmp_in;
    logic powered_up, hold_mode, result_valid, overtemp_indicator_o, overtemp_indicator_oe;
    logic [2:0] channel_sel = 3'h0, active_channel;
    logic [7:0] overtemp_setpoint = 8'h00;
    logic [9:0] level = 10'h000, dac_code, result;
    int err_count = 0, num_checks = 0, trk = 0;
    // open-drain pin with pull-up
    wire oti_pin = overtemp_indicator_oe ? overtemp_indicator_o : 1'b1;
    conv_ctrl dut (
        .mclk                   (mclk),
        .rst_n                  (rst_n),
        .conversion_start_input (conversion_start_input),
        .channel_sel            (channel_sel),
        .overtemp_setpoint      (overtemp_setpoint),
        .xfer_done              (xfer_done),
        .xfer_is_read           (xfer_is_read),
        .cmp_in                 (cmp_in),
        .powered_up             (powered_up),
        .hold_mode              (hold_mode),
        .active_channel         (active_channel),
        .dac_code               (dac_code),
        .result                 (result),
        .result_valid           (result_valid),
        .overtemp_indicator_o   (overtemp_indicator_o),
        .overtemp_indicator_oe  (overtemp_indicator_oe)
    );
    host_model host (
        .dac_code               (dac_code),
        .level                  (level),
        .mclk                   (mclk),
        .conversion_start_input (conversion_start_input),
        .xfer_done              (xfer_done),
        .xfer_is_read           (xfer_is_read),
        .cmp_in                 (cmp_in)
    );
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (powered_up && !hold_mode) trk++;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic conv(input int mode, input logic [11:0] len, input logic [11:0] e);
        int n;
        repeat (60) @(posedge mclk);
        trk = 0;
        if (mode == 0) host.pulse(len);
        else host.xfer(mode == 1);
        for (n = 0; n < 5000 && result_valid !== 1'b1; n++) @(negedge mclk);
        chk("valid", 16'h0001, 16'(result_valid));
        chk("track", e, 16'(trk));
    endtask
    task automatic summarize;
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge mclk) channel_sel <= rows[i].ch;
            level <= rows[i].lvl;
            overtemp_setpoint <= rows[i].sp;
            conv(0, rows[i].len, rows[i].ntrk);
            chk("result", 16'(rows[i].lvl), 16'(result));
            chk("channel", 16'(rows[i].ch), 16'(active_channel));
            @(negedge mclk) chk("oti", 16'(!rows[i].hot), 16'(oti_pin));
            @(posedge mclk) channel_sel <= 3'h4;
            conv(1, 12'h000, 12'h177);
            chk("oti_clr", 16'h0001, 16'(oti_pin));
            chk("result_ain", 16'(rows[i].lvl), 16'(result));
        end
        // second start during a conversion must be ignored
        @(posedge mclk) channel_sel <= 3'h0;
        fork
            conv(0, 12'h004, 12'h1f4);
            begin repeat (1000) @(posedge mclk); host.pulse(4); end
        join
        repeat (60) @(posedge mclk);
        host.pulse(4);
        repeat (800) @(posedge mclk);
        rst_n <= 1'b0;
        @(negedge mclk) chk("reset", 16'h0000, 16'({hold_mode, powered_up, overtemp_indicator_oe, result}));
        @(posedge mclk) rst_n <= 1'b1;
        conv(2, 12'h000, 12'h177);
        summarize;
    end
    initial begin
        repeat (90000) @(posedge mclk);
        err_count++;
        summarize;
    end
endmodule
